//--- logic/smpi_params.svh
`ifndef SMPI_PARAMS_SVH
`define SMPI_PARAMS_SVH

// ----------------------------------------
// buffer sizes
// ----------------------------------------
`define SMPI_RX_DEPTH 128
`define SMPI_TX_BITS 64
`define SMPI_PAYLOAD_BYTES 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define SMPI_SEQ_RESET 2'h0
`define SMPI_CNT_RESET 3'h0
`define SMPI_LINK_OK_RESET 1'h1
`define SMPI_DIAG_RESET 8'h00

// ----------------------------------------
// diagnostic byte bit positions
// ----------------------------------------
`define SMPI_DIAG_OVF 0
`define SMPI_DIAG_FRAME 1
`define SMPI_DIAG_HSHAKE 2
`define SMPI_DIAG_HW 3
`define SMPI_DIAG_PRM 4

`endif

//--- logic/smpi_pkg.sv
package smpi_pkg;

	// status byte, byte 0 of the input image
	typedef struct packed {
		logic link_ok;
		logic [1:0] out_seq_echo;
		logic [1:0] in_seq_count;
		logic [2:0] in_valid_bytes;
	} smpi_status_t;

	// control byte, byte 0 of the output image
	typedef struct packed {
		logic link_ok_reset;
		logic [1:0] out_seq_count;
		logic [1:0] in_seq_echo;
		logic [2:0] out_valid_bytes;
	} smpi_ctl_t;

	// clear byte, byte 1 of the output image
	typedef struct packed {
		logic [5:0] unused;
		logic transmit_clear_request;
		logic receive_clear_request;
	} smpi_clr_t;

	typedef struct packed {
		logic [47:0] payload;
		logic [7:0] diag;
		smpi_status_t status;
	} smpi_in_image_t;

	typedef struct packed {
		logic [47:0] payload;
		smpi_clr_t clr;
		smpi_ctl_t ctl;
	} smpi_out_image_t;

	typedef enum logic {ST_IDLE, ST_FILL} smpi_state_t;

endpackage

//--- logic/smpi_rx_fifo.sv
`timescale 1ns/1ps
`include "smpi_params.svh"

module smpi_rx_fifo #(
	parameter int DEPTH = `SMPI_RX_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic push_valid,
	input wire logic [7:0] push_data,
	input wire logic pop_ready,
	output logic pop_valid,
	output logic [7:0] pop_data,
	output logic overflow
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	wire full = (cnt_ff == (AW+1)'(DEPTH));
	wire do_pop = pop_ready & pop_valid & ~clear;
	wire do_push = push_valid & ~clear & (~full | do_pop);

	// ----------------------------------------
	// status toward the segment builder
	// ----------------------------------------
	assign pop_valid = (cnt_ff != '0);
	assign pop_data = mem[rd_ff];
	// a byte that finds no room is lost; only the flag remembers it
	assign overflow = push_valid & ~clear & full & ~do_pop;

	// storage has no reset, only pointers do
	always_ff @(posedge sys_clk)
	begin
		if (do_push)
			mem[wr_ff] <= push_data;
	end

	// pointers; clearing wins over a push in the same cycle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end
		else if (clear)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			wr_ff <= wr_ff + AW'(do_push);
			rd_ff <= rd_ff + AW'(do_pop);
			cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule

//--- logic/smpi_tx_buf.sv
`timescale 1ns/1ps
`include "smpi_params.svh"

module smpi_tx_buf #(
	parameter int BITS = `SMPI_TX_BITS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic load,
	input wire logic [47:0] load_data,
	input wire logic [2:0] load_count,
	input wire logic tx_ready,
	output logic busy,
	output logic tx_valid,
	output logic [7:0] tx_data
);
	logic [BITS-1:0] buf_ff;
	logic [3:0] left_ff;
	logic valid_ff;
	logic [3:0] nxt_left;
	logic [BITS-1:0] nxt_buf;
	wire shift = valid_ff & tx_ready;

	// ----------------------------------------
	// next state: clear, load, or shift a byte out
	// ----------------------------------------
	assign nxt_left = clear ? 4'h0 :
		load ? {1'b0, load_count} :
		shift ? left_ff - 4'h1 : left_ff;
	assign nxt_buf = load ? BITS'(load_data) :
		shift ? (buf_ff >> 8) : buf_ff;
	assign busy = (left_ff != 4'h0);
	assign tx_data = buf_ff[7:0];
	assign tx_valid = valid_ff;

	// valid kept as its own flop so the pin sees no logic
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			buf_ff <= '0;
			left_ff <= 4'h0;
			valid_ff <= 1'b0;
		end
		else
		begin
			buf_ff <= nxt_buf;
			left_ff <= nxt_left;
			valid_ff <= (nxt_left != 4'h0);
		end
	end
endmodule

//--- logic/smpi_top.sv
// Notes on behaviour
// - bytes from the field device are held in a 128-byte receive buffer and sent on in segments.
// - every input image is eight bytes: status, diagnostic flags, six payload bytes.
// - the diagnostic flag byte is always in the input image, whatever the diagnostics setting.
// - a falling edge of link_ok_reset from the controller sets link_ok back to 1, unless a fault arrives in the same cycle.
// - out_seq_echo carries the sequence count of the last output segment accepted.
// - in_seq_count on each input segment runs 00, 01, 10, 11 and wraps to 00.
// - in_valid_bytes tells how many payload bytes of the segment are valid, 1 to 6.
// - output payload goes into a 64-bit transmit buffer; the output image is eight bytes.
// - while link_ok_reset is 0, changes of the counts and the echo are ignored.
// - while link_ok_reset is 1, or as it rises, neither clear request acts.
// - receive_clear_request clears the receive buffer only while link_ok_reset is 0.
// - transmit_clear_request clears the transmit buffer, ignored while link_ok_reset is 1.
`timescale 1ns/1ps
`include "smpi_params.svh"

module smpi_top
	import smpi_pkg::*;
#(
	parameter int RX_DEPTH = `SMPI_RX_DEPTH,
	parameter int TX_BITS = `SMPI_TX_BITS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire smpi_out_image_t out_image,
	output smpi_in_image_t in_image,
	input wire logic field_rx_valid,
	input wire logic [7:0] field_rx_data,
	input wire logic field_rx_frame_err,
	output logic field_tx_valid,
	output logic [7:0] field_tx_data,
	input wire logic field_tx_ready,
	input wire logic hardware_failure_in,
	input wire logic parameter_error_in,
	input wire logic diagnostics_blocked,
	output logic diag_msg
);
	localparam int NPAY = `SMPI_PAYLOAD_BYTES;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [1:0] seq_next(input logic [1:0] s);
		seq_next = s + 2'h1;
	endfunction

	function automatic logic [47:0] put_byte(input logic [47:0] a, input logic [2:0] i,
		input logic [7:0] b);
		logic [47:0] r;
		r = a;
		r[i*8 +: 8] = b;
		put_byte = r;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	smpi_in_image_t in_image_ff;
	smpi_state_t state_ff;
	logic lor_q_ff;
	logic [1:0] ctl_seq_ff;
	logic [2:0] ctl_cnt_ff;
	logic [1:0] echo_ff;
	logic [47:0] asm_ff;
	logic [2:0] fill_ff;
	logic [7:0] diag_ff;
	logic link_ok_ff;
	logic [1:0] in_seq_ff;
	logic [1:0] out_echo_ff;
	logic [2:0] in_cnt_ff;
	logic [47:0] in_pay_ff;
	logic diag_msg_ff;

	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_ovf;
	logic tx_busy;

	// ----------------------------------------
	// controller side decode
	// ----------------------------------------
	wire lor = out_image.ctl.link_ok_reset;
	wire restore = lor_q_ff & ~lor;
	// a rise implies lor is 1 now, so masking on lor also covers the edge
	wire rx_clear = out_image.clr.receive_clear_request & ~lor;
	wire tx_clear = out_image.clr.transmit_clear_request & ~lor;
	wire ack_ok = (echo_ff == in_seq_ff);
	// new output segment recognised by a fresh sequence count
	wire accept = (ctl_seq_ff != out_echo_ff) & ~tx_busy & ~tx_clear;
	wire hs_err = accept & (ctl_seq_ff != seq_next(out_echo_ff));

	// ----------------------------------------
	// segment builder decode
	// ----------------------------------------
	wire filling = (state_ff == ST_FILL) & ~rx_clear;
	wire room = (fill_ff < 3'(NPAY));
	wire pop = filling & rx_valid & room;
	wire publish = filling & (~room | ~rx_valid);
	wire start = (state_ff == ST_IDLE) & ack_ok & rx_valid & ~rx_clear;

	// ----------------------------------------
	// diagnostics and link state
	// ----------------------------------------
	logic [7:0] new_diag;
	always_comb
	begin
		new_diag = 8'h00;
		new_diag[`SMPI_DIAG_OVF] = rx_ovf;
		new_diag[`SMPI_DIAG_FRAME] = field_rx_frame_err;
		new_diag[`SMPI_DIAG_HSHAKE] = hs_err;
		new_diag[`SMPI_DIAG_HW] = hardware_failure_in;
		new_diag[`SMPI_DIAG_PRM] = parameter_error_in;
	end
	wire disturb = (new_diag != 8'h00);
	// a fresh fault beats the restore edge in the same cycle
	wire [7:0] nxt_diag = (restore ? 8'h00 : diag_ff) | new_diag;
	wire nxt_link_ok = disturb ? 1'b0 : (restore ? 1'b1 : link_ok_ff);
	wire nxt_diag_msg = link_ok_ff & disturb & ~diagnostics_blocked;

	// ----------------------------------------
	// next values of the published image
	// ----------------------------------------
	wire [1:0] nxt_in_seq = publish ? seq_next(in_seq_ff) : in_seq_ff;
	wire [2:0] nxt_in_cnt = publish ? fill_ff : in_cnt_ff;
	wire [47:0] nxt_in_pay = publish ? asm_ff : in_pay_ff;
	wire [1:0] nxt_out_echo = accept ? ctl_seq_ff : out_echo_ff;
	smpi_in_image_t nxt_in_image;
	always_comb
	begin
		nxt_in_image.payload = nxt_in_pay;
		nxt_in_image.diag = nxt_diag;
		nxt_in_image.status.link_ok = nxt_link_ok;
		nxt_in_image.status.out_seq_echo = nxt_out_echo;
		nxt_in_image.status.in_seq_count = nxt_in_seq;
		nxt_in_image.status.in_valid_bytes = nxt_in_cnt;
	end

	assign in_image = in_image_ff;
	assign diag_msg = diag_msg_ff;

	// ----------------------------------------
	// receive buffer and transmit buffer
	// ----------------------------------------
	smpi_rx_fifo #(.DEPTH(RX_DEPTH)) u_rx (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(rx_clear),
		.push_valid(field_rx_valid),
		.push_data(field_rx_data),
		.pop_ready(pop),
		.pop_valid(rx_valid),
		.pop_data(rx_data),
		.overflow(rx_ovf)
	);

	// payload loaded with its own count; the count is latched, the data is live
	smpi_tx_buf #(.BITS(TX_BITS)) u_tx (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(tx_clear),
		.load(accept),
		.load_data(out_image.payload),
		.load_count(ctl_cnt_ff),
		.tx_ready(field_tx_ready),
		.busy(tx_busy),
		.tx_valid(field_tx_valid),
		.tx_data(field_tx_data)
	);

	// controller fields taken only while link_ok_reset is high
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lor_q_ff <= 1'b0;
			ctl_seq_ff <= `SMPI_SEQ_RESET;
			ctl_cnt_ff <= `SMPI_CNT_RESET;
			echo_ff <= `SMPI_SEQ_RESET;
		end
		else
		begin
			lor_q_ff <= lor;
			if (lor)
			begin
				ctl_seq_ff <= out_image.ctl.out_seq_count;
				ctl_cnt_ff <= out_image.ctl.out_valid_bytes;
				echo_ff <= out_image.ctl.in_seq_echo;
			end
		end
	end

	// segment builder: pops up to six bytes, then publishes
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= ST_IDLE;
			asm_ff <= '0;
			fill_ff <= `SMPI_CNT_RESET;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					fill_ff <= `SMPI_CNT_RESET;
					asm_ff <= '0;
					if (start)
						state_ff <= ST_FILL;
				end
				ST_FILL:
				begin
					if (rx_clear | publish)
						state_ff <= ST_IDLE;
					if (pop)
					begin
						asm_ff <= put_byte(asm_ff, fill_ff, rx_data);
						fill_ff <= fill_ff + 3'h1;
					end
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// published image and link status
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			link_ok_ff <= `SMPI_LINK_OK_RESET;
			diag_ff <= `SMPI_DIAG_RESET;
			in_seq_ff <= `SMPI_SEQ_RESET;
			out_echo_ff <= `SMPI_SEQ_RESET;
			in_cnt_ff <= `SMPI_CNT_RESET;
			in_pay_ff <= '0;
			in_image_ff <= '0;
			diag_msg_ff <= 1'b0;
		end
		else
		begin
			link_ok_ff <= nxt_link_ok;
			diag_ff <= nxt_diag;
			in_seq_ff <= nxt_in_seq;
			out_echo_ff <= nxt_out_echo;
			in_cnt_ff <= nxt_in_cnt;
			in_pay_ff <= nxt_in_pay;
			in_image_ff <= nxt_in_image;
			diag_msg_ff <= nxt_diag_msg;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_restore_clean;
		lor_q_ff & ~lor & ~disturb;
	endsequence

	link_restore_a: assert property (s_restore_clean |=> in_image.status.link_ok)
		else $error("link_ok not restored after falling link_ok_reset");
	link_fault_a: assert property (hardware_failure_in |=> ~in_image.status.link_ok)
		else $error("link_ok stays high during a fault");
	diag_always_a: assert property (hardware_failure_in
		|=> in_image.diag[`SMPI_DIAG_HW])
		else $error("hardware failure flag missing from input image");
	seq_wrap_a: assert property (publish
		|=> in_image.status.in_seq_count == $past(in_seq_ff) + 2'h1)
		else $error("in_seq_count did not advance by one");
	bytes_range_a: assert property (in_image.status.in_valid_bytes <= 3'(NPAY))
		else $error("in_valid_bytes beyond payload size");
	hold_segment_a: assert property (~ack_ok |=> $stable(in_seq_ff) && $stable(in_pay_ff))
		else $error("input segment changed before acknowledge");
	echo_copy_a: assert property (accept
		|=> in_image.status.out_seq_echo == $past(ctl_seq_ff))
		else $error("out_seq_echo does not match accepted segment");
	ctl_ignore_a: assert property (~lor |=> $stable(ctl_seq_ff) && $stable(echo_ff))
		else $error("control fields changed while link_ok_reset low");
	clear_block_a: assert property (lor && rx_valid && ~pop |=> rx_valid)
		else $error("receive buffer emptied while link_ok_reset high");
	rx_clear_a: assert property (rx_clear ##1 ~field_rx_valid |-> ~rx_valid)
		else $error("receive buffer not empty after clear");
	tx_clear_a: assert property (tx_clear |=> ~field_tx_valid)
		else $error("transmit buffer still sending after clear");
endmodule

//--- testbench/smpi_field_model.sv
`timescale 1ns/1ps

// serial field device: takes bytes with random stalls, sends bytes on request
module smpi_field_model
(
	input wire logic sys_clk,
	input wire logic field_tx_valid,
	input wire logic [7:0] field_tx_data,
	output logic field_tx_ready,
	output logic field_rx_valid,
	output logic [7:0] field_rx_data
);
	logic [7:0] got[$];

	initial
	begin
		field_tx_ready = 1'b0;
		field_rx_valid = 1'b0;
		field_rx_data = 8'h00;
	end

	// a byte counts only where valid and ready meet at an edge
	always @(posedge sys_clk)
	begin
		if (field_tx_valid === 1'b1 && field_tx_ready === 1'b1)
			got.push_back(field_tx_data);
		#1;
		field_tx_ready = 1'($urandom_range(0, 1));
	end

	// strobe stays up across a burst; idle data is inverted so no stale byte looks valid
	task automatic put_byte(input logic [7:0] b, input bit last);
		field_rx_valid = 1'b1;
		field_rx_data = b;
		@(posedge sys_clk);
		#1;
		if (last)
		begin
			field_rx_valid = 1'b0;
			field_rx_data = ~b;
		end
	endtask
endmodule

//--- testbench/smpi_top_bench.sv
`timescale 1ns/1ps

module smpi_top_bench
	import smpi_pkg::*;
;
	logic sys_clk;
	logic rst;
	smpi_out_image_t out_image;
	smpi_in_image_t in_image;
	logic field_rx_valid;
	logic [7:0] field_rx_data;
	logic field_tx_valid;
	logic [7:0] field_tx_data;
	logic field_tx_ready;
	logic hardware_failure_in;
	logic parameter_error_in;
	logic field_rx_frame_err;
	logic diagnostics_blocked;
	logic diag_msg;
	int fails;
	int n_checks;
	int cycles;
	int pulses;
	logic [1:0] exp_seq;
	logic [1:0] tx_seq;

	smpi_top u_smpi_top (
		.sys_clk(sys_clk),
		.rst(rst),
		.out_image(out_image),
		.in_image(in_image),
		.field_rx_valid(field_rx_valid),
		.field_rx_data(field_rx_data),
		.field_rx_frame_err(field_rx_frame_err),
		.field_tx_valid(field_tx_valid),
		.field_tx_data(field_tx_data),
		.field_tx_ready(field_tx_ready),
		.hardware_failure_in(hardware_failure_in),
		.parameter_error_in(parameter_error_in),
		.diagnostics_blocked(diagnostics_blocked),
		.diag_msg(diag_msg)
	);

	smpi_field_model u_smpi_field_model (
		.sys_clk(sys_clk),
		.field_tx_valid(field_tx_valid),
		.field_tx_data(field_tx_data),
		.field_tx_ready(field_tx_ready),
		.field_rx_valid(field_rx_valid),
		.field_rx_data(field_rx_data)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// pulse counter and hang guard; ceiling is over ten times the expected run
	always @(posedge sys_clk)
	begin
		cycles++;
		if (diag_msg === 1'b1)
			pulses++;
		if (cycles == 10000)
		begin
			fails++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// mode 0 plain, 1 clear while link_ok_reset high, 2 clear while low
	task automatic in_segment(input int n, input int mode);
		logic [47:0] pay;
		logic [47:0] mask;
		int i;
		pay = '0;
		mask = '0;
		for (int k = 0; k < n; k++)
		begin
			pay[8*k +: 8] = 8'($urandom);
			mask[8*k +: 8] = 8'hFF;
			u_smpi_field_model.put_byte(pay[8*k +: 8], k == n - 1);
		end
		tick(8);
		check(in_image.status.in_seq_count, exp_seq);
		out_image.clr.receive_clear_request = (mode != 0);
		if (mode == 2)
			out_image.ctl.link_ok_reset = 1'b0;
		tick(4);
		out_image.ctl.in_seq_echo = exp_seq;
		tick(6);
		out_image.clr.receive_clear_request = 1'b0;
		if (mode == 2)
		begin
			check(in_image.status.in_seq_count, exp_seq);
			out_image.ctl.link_ok_reset = 1'b1;
			tick(12);
			check(in_image.status.in_seq_count, exp_seq);
		end
		else
		begin
			i = 0;
			while (in_image.status.in_seq_count === exp_seq && i < 100)
			begin
				tick(1);
				i++;
			end
			exp_seq++;
			check(in_image.status, {1'b1, tx_seq, exp_seq, 3'(n)});
			check(in_image.payload & mask, pay);
		end
	endtask

	// count may be 0; hold keeps link_ok_reset low while the count moves
	task automatic out_segment(input int n, input bit hold);
		int i;
		u_smpi_field_model.got.delete();
		out_image.payload = {16'($urandom), 32'($urandom)};
		out_image.ctl.out_valid_bytes = 3'(n);
		tick(1);
		if (hold)
			out_image.ctl.link_ok_reset = 1'b0;
		out_image.ctl.out_seq_count = tx_seq + 2'h1;
		if (hold)
		begin
			tick(8);
			check(in_image.status.out_seq_echo, tx_seq);
			out_image.ctl.link_ok_reset = 1'b1;
		end
		tx_seq++;
		i = 0;
		while (in_image.status.out_seq_echo !== tx_seq && i < 50)
		begin
			tick(1);
			i++;
		end
		check(in_image.status.out_seq_echo, tx_seq);
		i = 0;
		while (u_smpi_field_model.got.size() < n && i < 300)
		begin
			tick(1);
			i++;
		end
		tick(20);
		check(u_smpi_field_model.got.size(), n);
		for (int k = 0; k < u_smpi_field_model.got.size() && k < n; k++)
			check(u_smpi_field_model.got[k], out_image.payload[8*k +: 8]);
	endtask

	// clear request held while a 6-byte segment is going out
	task automatic out_flush;
		int s;
		u_smpi_field_model.got.delete();
		out_image.clr.transmit_clear_request = 1'b1;
		out_image.ctl.out_valid_bytes = 3'h6;
		tick(1);
		out_image.ctl.out_seq_count = tx_seq + 2'h1;
		tx_seq++;
		tick(2);
		check(field_tx_valid, 1'b1);
		out_image.ctl.link_ok_reset = 1'b0;
		tick(1);
		s = u_smpi_field_model.got.size();
		check(field_tx_valid, 1'b0);
		tick(10);
		check(u_smpi_field_model.got.size(), s);
		out_image.clr.transmit_clear_request = 1'b0;
		out_image.ctl.link_ok_reset = 1'b1;
		tick(2);
	endtask

	// one fault (0 hw, 1 skipped count, 2 framing, 3 parameter), then restore
	task automatic fault(input logic blocked, input int kind, input logic [8:0] exp_diag);
		int p;
		p = pulses;
		diagnostics_blocked = blocked;
		if (kind == 1)
		begin
			out_image.ctl.out_valid_bytes = 3'h0;
			out_image.ctl.out_seq_count = tx_seq + 2'h2;
			tx_seq += 2'h2;
		end
		hardware_failure_in = (kind == 0);
		field_rx_frame_err = (kind == 2);
		parameter_error_in = (kind == 3);
		tick(1);
		hardware_failure_in = 1'b0;
		field_rx_frame_err = 1'b0;
		parameter_error_in = 1'b0;
		tick(3);
		check({in_image.status.link_ok, in_image.diag}, exp_diag);
		check(pulses - p, blocked ? 0 : 1);
		out_image.ctl.link_ok_reset = 1'b0;
		tick(4);
		check({in_image.status.link_ok, in_image.diag}, 9'h100);
		out_image.ctl.link_ok_reset = 1'b1;
		tick(2);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	// echo starts off the segment count so the empty first segment stays unacknowledged
	initial
	begin
		void'($urandom(32'hA965));
		rst = 1'b1;
		out_image = '0;
		out_image.ctl.link_ok_reset = 1'b1;
		out_image.ctl.in_seq_echo = 2'h3;
		hardware_failure_in = 1'b0;
		parameter_error_in = 1'b0;
		field_rx_frame_err = 1'b0;
		diagnostics_blocked = 1'b0;
		exp_seq = 2'h0;
		tx_seq = 2'h0;
		tick(20);
		rst = 1'b0;
		tick(2);
		check({in_image.diag, in_image.status}, 16'h0080);
		in_segment(6, 0);
		for (int k = 0; k < 5; k++)
			in_segment($urandom_range(1, 6), 0);
		in_segment(2, 1);
		in_segment(3, 2);
		$display("input segment tests done");
		for (int k = 0; k < 6; k++)
			out_segment((k == 0) ? 0 : $urandom_range(1, 6), k == 3);
		out_flush();
		$display("output segment tests done");
		fault(1'b1, 0, 9'h008);
		fault(1'b0, 0, 9'h008);
		fault(1'b0, 1, 9'h004);
		fault(1'b1, 2, 9'h002);
		fault(1'b0, 3, 9'h010);
		$display("link status tests done");
		end_of_test();
	end
endmodule
